// *** rtl/bcfu_top.sv ***
// bcfu_top.sv: program flow unit, next pc, compares, skips, branches
// assumes: operands and strobes come from logic on core_clk, no sync
// needed; the issuer holds off while busy_r is high.
//
// Behaviour
// RULE1: relative jump loads pc plus offset plus one in two cycles.
// RULE2: pointer jump two cycles, absolute jump to immediate three cycles.
// RULE3: relative and pointer calls take three cycles, absolute four.
// RULE4: compare_skip_equal skips next instruction when registers are equal.
// RULE5: compares only update Z, N, V, C, H and S in one cycle.
// RULE6: register bit skips test chosen bit clear or set.
// RULE7: I/O bit skips test chosen bit of I/O value.
// RULE8: generic flag branches test indexed status bit set or clear.
// RULE9: branch_equal taken on Z one, branch_not_equal on Z zero.
// RULE10: carry set and lower on C one; clear and same-or-higher on zero.
// RULE11: branch_minus on N one, branch_plus on N zero.
// RULE12: signed greater-or-equal taken when N xor V is zero.
// RULE13: signed less-than taken when N xor V is one, flags untouched.
// RULE14: half carry branches taken on H one or H zero.
// RULE15: branch costs one untaken, two taken; skips cost one, two, three.
// RULE16: every call pushes its return address before pc is redirected.
`timescale 1ns/1ps
`include "bcfu_regs.svh"
module bcfu_top import bcfu_pkg::*; (
   input  wire logic                    core_clk,     // core clock, 20 MHz
   input  wire logic                    rst,          // async reset, high
   input  wire logic                    clk_en,       // freezes all state low
   input  wire logic                    op_valid,     // issue strobe
   input  wire bcfu_op_t                op_code,      // operation
   input  wire logic [`BCFU_OFS_W-1:0]  rel_offset,   // signed word offset
   input  wire logic [`BCFU_PC_W-1:0]   imm_target,   // absolute target
   input  wire logic [`BCFU_PC_W-1:0]   pointer_val,  // pointer register
   input  wire logic [`BCFU_DATA_W-1:0] rd_val,       // first register
   input  wire logic [`BCFU_DATA_W-1:0] rr_val,       // second register
   input  wire logic [`BCFU_DATA_W-1:0] imm_val,      // compare immediate
   input  wire logic [`BCFU_DATA_W-1:0] io_val,       // addressed I/O byte
   input  wire logic [2:0]              bit_sel,      // bit or flag index
   input  wire logic                    next_two_word,// next instr is 2 words
   input  wire logic                    flags_load,   // overwrite flags
   input  wire logic [7:0]              flags_in,     // value to load
   output logic      [`BCFU_PC_W-1:0]   pc_r,         // program counter
   output logic      [7:0]              status_r,     // status flags
   output logic                         busy_r,       // multi-cycle in work
   output logic                         done_r,       // instruction retired
   output logic      [`BCFU_COST_W-1:0] cost_r,       // cycles of last instr
   output logic                         push_valid_r, // return address push
   output logic      [`BCFU_PC_W-1:0]   push_addr_r   // return address
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [`BCFU_PC_W-1:0] rel_target(
      input logic [`BCFU_PC_W-1:0]  pc,
      input logic [`BCFU_OFS_W-1:0] ofs
   );
      logic [`BCFU_PC_W-1:0] sext;
      sext = {{(`BCFU_PC_W-`BCFU_OFS_W){ofs[`BCFU_OFS_W-1]}}, ofs};
      // wraps modulo program space, as the core does
      rel_target = pc + sext + `BCFU_STEP_ONE;
   endfunction

   function automatic logic [`BCFU_PC_W-1:0] skip_target(
      input logic [`BCFU_PC_W-1:0] pc,
      input logic                  skip,
      input logic                  two_word
   );
      logic [`BCFU_PC_W-1:0] step;
      step = two_word ? `BCFU_STEP_TWO : `BCFU_STEP_ONE;
      skip_target = skip ? pc + `BCFU_STEP_ONE + step : pc + `BCFU_STEP_ONE;
   endfunction

   function automatic logic [`BCFU_COST_W-1:0] skip_cost(
      input logic skip,
      input logic two_word
   );
      if (!skip)
         skip_cost = `BCFU_CYC_ONE;
      else if (two_word)
         skip_cost = `BCFU_CYC_THREE;
      else
         skip_cost = `BCFU_CYC_TWO;
   endfunction

   function automatic logic [`BCFU_COST_W-1:0] branch_cost(
      input logic taken
   );
      branch_cost = taken ? `BCFU_CYC_TWO : `BCFU_CYC_ONE;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // compare datapath

   logic [7:0]              cmp_flags;
   logic                    cmp_equal;
   logic [`BCFU_DATA_W-1:0] cmp_rhs;
   logic                    cmp_chain;

   assign cmp_rhs   = (op_code == OP_COMPARE_IMMEDIATE) ? imm_val : rr_val;
   assign cmp_chain = (op_code == OP_COMPARE_WITH_CARRY);

   bcfu_cmp u_cmp (
      .lhs       (rd_val),
      .rhs       (cmp_rhs),
      .use_carry (cmp_chain),
      .flags_in  (status_r),
      .flags_out (cmp_flags),
      .equal     (cmp_equal)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode of one issued operation

   logic [`BCFU_PC_W-1:0]   dec_target;
   logic [`BCFU_COST_W-1:0] dec_cost;
   logic                    dec_push;
   logic [`BCFU_PC_W-1:0]   dec_ret;
   logic                    dec_flags_we;
   logic                    taken;
   logic                    nxv;

   always_comb begin
      dec_target   = pc_r + `BCFU_STEP_ONE;
      dec_cost     = `BCFU_CYC_ONE;
      dec_push     = 1'b0;
      dec_ret      = pc_r + `BCFU_STEP_ONE;
      dec_flags_we = 1'b0;
      taken        = 1'b0;
      nxv          = status_r[`BCFU_FLAG_N] ^ status_r[`BCFU_FLAG_V];
      case (op_code)
         OP_RELATIVE_JUMP: begin
            dec_target = rel_target(pc_r, rel_offset);      // [RULE1]
            dec_cost   = `BCFU_CYC_TWO;                     // [RULE1]
         end
         OP_POINTER_JUMP: begin
            dec_target = pointer_val;                       // [RULE2]
            dec_cost   = `BCFU_CYC_TWO;                     // [RULE2]
         end
         OP_ABSOLUTE_JUMP: begin
            dec_target = imm_target;                        // [RULE2]
            dec_cost   = `BCFU_CYC_THREE;                   // [RULE2]
         end
         OP_RELATIVE_CALL: begin
            dec_target = rel_target(pc_r, rel_offset);
            dec_cost   = `BCFU_CYC_THREE;                   // [RULE3]
            dec_push   = 1'b1;                              // [RULE16]
         end
         OP_POINTER_CALL: begin
            dec_target = pointer_val;
            dec_cost   = `BCFU_CYC_THREE;                   // [RULE3]
            dec_push   = 1'b1;                              // [RULE16]
         end
         OP_ABSOLUTE_CALL: begin
            dec_target = imm_target;
            dec_cost   = `BCFU_CYC_FOUR;                    // [RULE3]
            dec_push   = 1'b1;                              // [RULE16]
            // call itself holds the target word, so return past it
            dec_ret    = pc_r + `BCFU_STEP_TWO;             // [RULE16]
         end
         OP_COMPARE_SKIP_EQUAL: begin
            taken      = cmp_equal;                         // [RULE4]
         end
         OP_REGISTER_COMPARE, OP_COMPARE_WITH_CARRY,
         OP_COMPARE_IMMEDIATE: begin
            dec_flags_we = 1'b1;                            // [RULE5]
         end
         OP_SKIP_REG_BIT_CLEAR: taken = ~rr_val[bit_sel];   // [RULE6]
         OP_SKIP_REG_BIT_SET:   taken =  rr_val[bit_sel];   // [RULE6]
         OP_SKIP_IO_BIT_CLEAR:  taken = ~io_val[bit_sel];   // [RULE7]
         OP_SKIP_IO_BIT_SET:    taken =  io_val[bit_sel];   // [RULE7]
         OP_BRANCH_FLAG_SET:    taken =  status_r[bit_sel]; // [RULE8]
         OP_BRANCH_FLAG_CLEAR:  taken = ~status_r[bit_sel]; // [RULE8]
         OP_BRANCH_EQUAL:       taken =  status_r[`BCFU_FLAG_Z]; // [RULE9]
         OP_BRANCH_NOT_EQUAL:   taken = ~status_r[`BCFU_FLAG_Z]; // [RULE9]
         OP_BRANCH_CARRY_SET,
         OP_BRANCH_LOWER:       taken =  status_r[`BCFU_FLAG_C]; // [RULE10]
         OP_BRANCH_CARRY_CLEAR,
         OP_BRANCH_SAME_OR_HIGHER:
                                taken = ~status_r[`BCFU_FLAG_C]; // [RULE10]
         OP_BRANCH_MINUS:       taken =  status_r[`BCFU_FLAG_N]; // [RULE11]
         OP_BRANCH_PLUS:        taken = ~status_r[`BCFU_FLAG_N]; // [RULE11]
         OP_BRANCH_SIGNED_GE:   taken = ~nxv;                    // [RULE12]
         OP_BRANCH_SIGNED_LT:   taken =  nxv;                    // [RULE13]
         OP_BRANCH_HALF_CARRY_SET:
                                taken =  status_r[`BCFU_FLAG_H]; // [RULE14]
         OP_BRANCH_HALF_CARRY_CLEAR:
                                taken = ~status_r[`BCFU_FLAG_H]; // [RULE14]
         default: begin
            dec_target = pc_r + `BCFU_STEP_ONE;
         end
      endcase
      case (op_code)
         OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
         OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
            dec_target = skip_target(pc_r, taken, next_two_word); // [RULE4]
            dec_cost   = skip_cost(taken, next_two_word);       // [RULE15]
         end
         OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL,
         OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
         OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER, OP_BRANCH_MINUS,
         OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
         OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR: begin
            dec_target = taken ? rel_target(pc_r, rel_offset)
                               : pc_r + `BCFU_STEP_ONE;     // [RULE8]
            dec_cost   = branch_cost(taken);                // [RULE15]
         end
         default: begin
            dec_cost = dec_cost;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer

   bcfu_state_t             state_r;
   bcfu_state_t             state_nxt;
   logic [`BCFU_PC_W-1:0]   pc_nxt;
   logic [`BCFU_PC_W-1:0]   pend_pc_r;
   logic [`BCFU_PC_W-1:0]   pend_pc_nxt;
   logic [`BCFU_COST_W-1:0] left_r;
   logic [`BCFU_COST_W-1:0] left_nxt;
   logic [`BCFU_COST_W-1:0] cost_nxt;
   logic [7:0]              status_nxt;
   logic                    busy_nxt;
   logic                    done_nxt;
   logic                    push_valid_nxt;
   logic [`BCFU_PC_W-1:0]   push_addr_nxt;

   always_comb begin
      state_nxt      = state_r;
      pc_nxt         = pc_r;
      pend_pc_nxt    = pend_pc_r;
      left_nxt       = left_r;
      cost_nxt       = cost_r;
      status_nxt     = flags_load ? flags_in : status_r;
      busy_nxt       = busy_r;
      done_nxt       = 1'b0;
      push_valid_nxt = 1'b0;
      push_addr_nxt  = push_addr_r;
      case (state_r)
         ST_IDLE: begin
            if (op_valid) begin
               cost_nxt = dec_cost;
               // compare result wins over a same-cycle external load
               if (dec_flags_we)
                  status_nxt = cmp_flags;                   // [RULE5]
               if (dec_push) begin
                  // push leaves before the pc moves, so it is never lost
                  push_valid_nxt = 1'b1;                    // [RULE16]
                  push_addr_nxt  = dec_ret;                 // [RULE16]
               end
               if (dec_cost == `BCFU_CYC_ONE) begin
                  pc_nxt   = dec_target;
                  done_nxt = 1'b1;
               end else begin
                  state_nxt   = ST_EXEC;
                  pend_pc_nxt = dec_target;
                  left_nxt    = dec_cost - `BCFU_CYC_ONE;   // [RULE15]
                  busy_nxt    = 1'b1;
               end
            end
         end
         ST_EXEC: begin
            left_nxt = left_r - `BCFU_CYC_ONE;
            if (left_r == `BCFU_CYC_ONE) begin
               pc_nxt    = pend_pc_r;                       // [RULE1]
               done_nxt  = 1'b1;
               busy_nxt  = 1'b0;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            busy_nxt  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r      <= ST_IDLE;
         pc_r         <= `BCFU_PC_RST;
         pend_pc_r    <= `BCFU_PC_RST;
         left_r       <= '0;
         cost_r       <= '0;
         status_r     <= `BCFU_FLAGS_RST;
         busy_r       <= 1'b0;
         done_r       <= 1'b0;
         push_valid_r <= 1'b0;
         push_addr_r  <= `BCFU_PC_RST;
      end else if (clk_en) begin
         state_r      <= state_nxt;
         pc_r         <= pc_nxt;
         pend_pc_r    <= pend_pc_nxt;
         left_r       <= left_nxt;
         cost_r       <= cost_nxt;
         status_r     <= status_nxt;
         busy_r       <= busy_nxt;
         done_r       <= done_nxt;
         push_valid_r <= push_valid_nxt;
         push_addr_r  <= push_addr_nxt;
      end
   end

endmodule

// *** rtl/bcfu_regs.svh ***
// bcfu_regs.svh: widths, flag positions, cycle costs and pc steps
// assumes: included by bare name from the package and the design modules
`ifndef BCFU_REGS_SVH
`define BCFU_REGS_SVH

`define BCFU_PC_W        16
`define BCFU_OFS_W       12
`define BCFU_DATA_W      8
`define BCFU_COST_W      3

`define BCFU_PC_RST      16'h0000
`define BCFU_FLAGS_RST   8'h00

// status flag positions
`define BCFU_FLAG_C      3'h0
`define BCFU_FLAG_Z      3'h1
`define BCFU_FLAG_N      3'h2
`define BCFU_FLAG_V      3'h3
`define BCFU_FLAG_S      3'h4
`define BCFU_FLAG_H      3'h5

// cycle costs
`define BCFU_CYC_ONE     3'h1
`define BCFU_CYC_TWO     3'h2
`define BCFU_CYC_THREE   3'h3
`define BCFU_CYC_FOUR    3'h4

// program counter steps, in words
`define BCFU_STEP_ONE    16'h0001
`define BCFU_STEP_TWO    16'h0002

`endif

// *** rtl/bcfu_pkg.sv ***
// bcfu_pkg.sv: operation codes and state type of the flow unit
// assumes: bcfu_regs.svh sits on the include path
`include "bcfu_regs.svh"
package bcfu_pkg;

   typedef enum logic [4:0] {
      OP_SEQUENTIAL           = 5'h00,
      OP_RELATIVE_JUMP        = 5'h01,
      OP_POINTER_JUMP         = 5'h02,
      OP_ABSOLUTE_JUMP        = 5'h03,
      OP_RELATIVE_CALL        = 5'h04,
      OP_POINTER_CALL         = 5'h05,
      OP_ABSOLUTE_CALL        = 5'h06,
      OP_COMPARE_SKIP_EQUAL   = 5'h07,
      OP_REGISTER_COMPARE     = 5'h08,
      OP_COMPARE_WITH_CARRY   = 5'h09,
      OP_COMPARE_IMMEDIATE    = 5'h0A,
      OP_SKIP_REG_BIT_CLEAR   = 5'h0B,
      OP_SKIP_REG_BIT_SET     = 5'h0C,
      OP_SKIP_IO_BIT_CLEAR    = 5'h0D,
      OP_SKIP_IO_BIT_SET      = 5'h0E,
      OP_BRANCH_FLAG_SET      = 5'h0F,
      OP_BRANCH_FLAG_CLEAR    = 5'h10,
      OP_BRANCH_EQUAL         = 5'h11,
      OP_BRANCH_NOT_EQUAL     = 5'h12,
      OP_BRANCH_CARRY_SET     = 5'h13,
      OP_BRANCH_CARRY_CLEAR   = 5'h14,
      OP_BRANCH_SAME_OR_HIGHER = 5'h15,
      OP_BRANCH_LOWER         = 5'h16,
      OP_BRANCH_MINUS         = 5'h17,
      OP_BRANCH_PLUS          = 5'h18,
      OP_BRANCH_SIGNED_GE     = 5'h19,
      OP_BRANCH_SIGNED_LT     = 5'h1A,
      OP_BRANCH_HALF_CARRY_SET = 5'h1B,
      OP_BRANCH_HALF_CARRY_CLEAR = 5'h1C
   } bcfu_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1
   } bcfu_state_t;

endpackage

// *** rtl/bcfu_cmp.sv ***
// bcfu_cmp.sv: subtract-only compare, produces new status flags
// assumes: purely combinational, operands from the same clock domain
`timescale 1ns/1ps
`include "bcfu_regs.svh"
module bcfu_cmp import bcfu_pkg::*; (
   input  wire logic [`BCFU_DATA_W-1:0] lhs,       // minuend
   input  wire logic [`BCFU_DATA_W-1:0] rhs,       // subtrahend
   input  wire logic                    use_carry, // chain carry and zero
   input  wire logic [7:0]              flags_in,  // current flags
   output logic      [7:0]              flags_out, // updated flags
   output logic                         equal      // lhs equals rhs
);

   logic [`BCFU_DATA_W:0]   diff;
   logic                    cin;
   logic [`BCFU_DATA_W-1:0] res;

   always_comb begin
      cin       = use_carry & flags_in[`BCFU_FLAG_C];
      diff      = {1'b0, lhs} - {1'b0, rhs} - {8'h00, cin};
      res       = diff[`BCFU_DATA_W-1:0];
      equal     = (lhs == rhs);
      flags_out = flags_in;
      flags_out[`BCFU_FLAG_C] = diff[`BCFU_DATA_W];
      flags_out[`BCFU_FLAG_N] = res[7];
      flags_out[`BCFU_FLAG_V] = (lhs[7] & ~rhs[7] & ~res[7])
                              | (~lhs[7] & rhs[7] & res[7]);
      flags_out[`BCFU_FLAG_H] = (~lhs[3] & rhs[3]) | (rhs[3] & res[3])
                              | (res[3] & ~lhs[3]);
      // chained compare keeps zero only if earlier bytes were equal
      flags_out[`BCFU_FLAG_Z] = (res == 8'h00)
                              & (~use_carry | flags_in[`BCFU_FLAG_Z]);
      flags_out[`BCFU_FLAG_S] = res[7] ^ flags_out[`BCFU_FLAG_V];
   end

endmodule

// *** tb/bcfu_top_monitor.sv ***
// bcfu_top_monitor.sv: port-level timing and flow checks for bcfu_top
// assumes: bound into bcfu_top, clk_en held high while ops run
`timescale 1ns/1ps
module bcfu_top_monitor import bcfu_pkg::*; (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic        op_valid,
   input wire bcfu_op_t    op_code,
   input wire logic [11:0] rel_offset,
   input wire logic [15:0] imm_target,
   input wire logic [15:0] pointer_val,
   input wire logic [7:0]  rr_val,
   input wire logic [2:0]  bit_sel,
   input wire logic        next_two_word,
   input wire logic        flags_load,
   input wire logic [15:0] pc_r,
   input wire logic [7:0]  status_r,
   input wire logic        busy_r,
   input wire logic        done_r,
   input wire logic [2:0]  cost_r,
   input wire logic        push_valid_r,
   input wire logic [15:0] push_addr_r
);
////////////////////////////////////////////////////////////////////////////
   // busy_r mirrors the exec state, so the unit takes ops while it is low
   logic        acc;
   logic [15:0] ofs16;
   logic        is_cmp;
   assign acc = clk_en && op_valid && !busy_r;
   assign ofs16 = {{4{rel_offset[11]}}, rel_offset};
   assign is_cmp = op_code inside {OP_REGISTER_COMPARE,
                   OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE};
////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_rel_jump;
      acc && op_code == OP_RELATIVE_JUMP |=> busy_r && !done_r ##1 done_r
         && cost_r == 3'h2
         && pc_r == $past(pc_r, 2) + $past(ofs16, 2) + 16'h0001;
   endproperty
   a_rel_jump: assert property (p_rel_jump) else $error("rel jump");
   property p_ptr_jump;
      acc && op_code == OP_POINTER_JUMP |=> !done_r ##1 done_r
         && pc_r == $past(pointer_val, 2);
   endproperty
   a_ptr_jump: assert property (p_ptr_jump) else $error("ptr jump");
   property p_abs_call;
      acc && op_code == OP_ABSOLUTE_CALL |=> push_valid_r
         && push_addr_r == $past(pc_r) + 16'h0002 ##1 !done_r ##1 !done_r
         ##1 done_r && cost_r == 3'h4 && pc_r == $past(imm_target, 4);
   endproperty
   a_abs_call: assert property (p_abs_call)
      else $error("call");
   property p_compare;
      acc && is_cmp |=> done_r && cost_r == 3'h1
         && pc_r == $past(pc_r) + 16'h0001;
   endproperty
   a_compare: assert property (p_compare) else $error("compare");
   property p_skip_far;
      acc && op_code == OP_SKIP_REG_BIT_SET && rr_val[bit_sel]
         && next_two_word |=> !done_r ##1 !done_r ##1 done_r
         && pc_r == $past(pc_r, 3) + 16'h0003;
   endproperty
   a_skip_far: assert property (p_skip_far)
      else $error("skip");
   property p_br_eq;
      acc && op_code == OP_BRANCH_EQUAL |=> done_r == !$past(status_r[1]);
   endproperty
   a_br_eq: assert property (p_br_eq) else $error("branch eq");
   property p_br_lt;
      acc && op_code == OP_BRANCH_SIGNED_LT
         |=> done_r == ($past(status_r[2]) == $past(status_r[3]));
   endproperty
   a_br_lt: assert property (p_br_lt) else $error("branch lt");
   property p_flag_hold;
      acc && !flags_load && !is_cmp |=> status_r == $past(status_r);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flags");
   property p_push_one;
      push_valid_r |=> !push_valid_r;
   endproperty
   a_push_one: assert property (p_push_one) else $error("push");
   c_taken: cover property (done_r && cost_r == 3'h2);
   c_push: cover property (push_valid_r);
   c_three: cover property (done_r && cost_r == 3'h3);
endmodule

bind bcfu_top bcfu_top_monitor mon_u (
   .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
   .op_code(op_code), .rel_offset(rel_offset), .imm_target(imm_target),
   .pointer_val(pointer_val), .rr_val(rr_val), .bit_sel(bit_sel),
   .next_two_word(next_two_word), .flags_load(flags_load),
   .pc_r(pc_r), .status_r(status_r), .busy_r(busy_r),
   .done_r(done_r), .cost_r(cost_r), .push_valid_r(push_valid_r),
   .push_addr_r(push_addr_r));

// *** tb/branch_control_flow_unit_bench.sv ***
// branch_control_flow_unit_bench.sv: directed tests of the flow unit
// assumes: bcfu_top with its monitor bound in, one 20 MHz clock
`timescale 1ns/1ps
`include "bcfu_regs.svh"
module branch_control_flow_unit_bench import bcfu_pkg::*;;
   logic        core_clk, rst, clk_en, op_valid, next_two_word, flags_load;
   bcfu_op_t    op_code;
   logic [11:0] rel_offset, k;
   logic [15:0] imm_target, pointer_val, pc_r, push_addr_r, pc_m, ret, e_pc;
   logic [7:0]  rd_val, rr_val, imm_val, io_val, flags_in, status_r, f, b;
   logic [2:0]  bit_sel, cost_r, e_c, sel, idx;
   logic        busy_r, done_r, push_valid_r, cond, s;
   int          fail_count, n_compared;
   bcfu_op_t cp_op [5] = '{OP_REGISTER_COMPARE, OP_COMPARE_IMMEDIATE,
      OP_COMPARE_WITH_CARRY, OP_COMPARE_WITH_CARRY, OP_COMPARE_WITH_CARRY};
   logic [7:0] cp_a [5] = '{8'h10, 8'h80, 8'h05, 8'h05, 8'h05};
   logic [7:0] cp_b [5] = '{8'h20, 8'h01, 8'h05, 8'h04, 8'h04};
   logic [7:0] cp_pri [5] = '{8'hC0, 8'hC0, 8'hC1, 8'hC1, 8'hC3};
   logic [7:0] cp_exp [5] = '{8'hD5, 8'hF8, 8'hF5, 8'hC0, 8'hC2};
   bcfu_op_t sk_op [5] = '{OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
   logic sk_set [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   bcfu_op_t br_op [14] = '{OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
      OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER,
      OP_BRANCH_LOWER, OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LT, OP_BRANCH_HALF_CARRY_SET,
      OP_BRANCH_HALF_CARRY_CLEAR, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR};
   logic [2:0] br_idx [14] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2,
      3'h2, 3'h2, 3'h2, 3'h5, 3'h5, 3'h0, 3'h0};
   logic br_pol [14] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
      1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

   bcfu_top dut_u (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
      .op_code(op_code), .rel_offset(rel_offset), .imm_target(imm_target),
      .pointer_val(pointer_val), .rd_val(rd_val), .rr_val(rr_val),
      .imm_val(imm_val), .io_val(io_val), .bit_sel(bit_sel),
      .next_two_word(next_two_word), .flags_load(flags_load),
      .flags_in(flags_in), .pc_r(pc_r), .status_r(status_r),
      .busy_r(busy_r), .done_r(done_r), .cost_r(cost_r),
      .push_valid_r(push_valid_r), .push_addr_r(push_addr_r));
////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function logic [15:0] rel(input logic [11:0] ofs);
      return pc_m + {{4{ofs[11]}}, ofs} + 16'h0001;
   endfunction

   task set_flags(input logic [7:0] v);
      @(posedge core_clk);
      flags_load <= 1'b1;
      flags_in <= v;
      @(posedge core_clk);
      flags_load <= 1'b0;
   endtask

   // issue one op, bounded wait for done, check pc and cost
   task run_op(input bcfu_op_t op, input logic [11:0] ofs,
               input logic [7:0] a, input logic [7:0] v,
               input logic [2:0] bs, input logic tw,
               input logic [15:0] x_pc, input logic [2:0] x_c);
      int n;
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_code <= op;
      rel_offset <= ofs;
      rd_val <= a;
      imm_val <= v;
      io_val <= v;
      // for the immediate compare and I/O skips, rr_val carries the inverted byte
      rr_val <= (op inside {OP_COMPARE_IMMEDIATE, OP_SKIP_IO_BIT_CLEAR,
                 OP_SKIP_IO_BIT_SET}) ? ~v : v;
      bit_sel <= bs;
      next_two_word <= tw;
      @(posedge core_clk);
      op_valid <= 1'b0;
      n = 1;
      #1;
      while (done_r !== 1'b1 && n < 8) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(pc_r, x_pc);
      chk(16'(cost_r), 16'(x_c));
      chk(16'(n), 16'(x_c));
      pc_m = x_pc;
   endtask
////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {clk_en, op_valid, next_two_word, flags_load} = 4'h8;
      op_code = OP_SEQUENTIAL;
      {rel_offset, rd_val, rr_val, imm_val, io_val, flags_in} = '0;
      bit_sel = 3'h0;
      imm_target = 16'h0ABC;
      pointer_val = 16'h1234;
      pc_m = 16'h0000;
      fail_count = 0;
      n_compared = 0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      set_flags(8'hA5);
      run_op(OP_RELATIVE_JUMP, 12'h005, 8'h00, 8'h00, 3'h0, 1'b0,
             rel(12'h005), 3'h2);
      run_op(OP_RELATIVE_JUMP, 12'hFFD, 8'h00, 8'h00, 3'h0, 1'b0,
             rel(12'hFFD), 3'h2);
      run_op(OP_POINTER_JUMP, 12'h000, 8'h00, 8'h00, 3'h0, 1'b0,
             16'h1234, 3'h2);
      run_op(OP_ABSOLUTE_JUMP, 12'h000, 8'h00, 8'h00, 3'h0, 1'b0,
             16'h0ABC, 3'h3);
      ret = pc_m + 16'h0001;
      run_op(OP_RELATIVE_CALL, 12'h004, 8'h00, 8'h00, 3'h0, 1'b0,
             rel(12'h004), 3'h3);
      chk(push_addr_r, ret);
      ret = pc_m + 16'h0001;
      run_op(OP_POINTER_CALL, 12'h000, 8'h00, 8'h00, 3'h0, 1'b0,
             16'h1234, 3'h3);
      chk(push_addr_r, ret);
      ret = pc_m + 16'h0002;
      run_op(OP_ABSOLUTE_CALL, 12'h000, 8'h00, 8'h00, 3'h0, 1'b0,
             16'h0ABC, 3'h4);
      chk(push_addr_r, ret);
      // frozen unit must ignore this load
      clk_en <= 1'b0;
      set_flags(8'h3C);
      clk_en <= 1'b1;
      #1;
      chk(16'(status_r), 16'h00A5);
      for (int i = 0; i < 5; i++) begin
         set_flags(cp_pri[i]);
         run_op(cp_op[i], 12'h000, cp_a[i], cp_b[i], 3'h0, 1'b0,
                pc_m + 16'h0001, 3'h1);
         chk(16'(status_r), 16'(cp_exp[i]));
      end
      set_flags(8'h5A);
      for (int i = 0; i < 5; i++)
         for (int j = 0; j < 4; j++) begin
            s = j[1];
            sel = 3'(i + 2);
            cond = sk_set[i] ? s : !s;
            b = cond ? 8'h01 << sel : ~(8'h01 << sel);
            if (i == 0) b = s ? 8'h3C : 8'h3D;
            e_c = s ? (j[0] ? 3'h3 : 3'h2) : 3'h1;
            run_op(sk_op[i], 12'h000, 8'h3C, b, sel, j[0],
                   pc_m + 16'(e_c), e_c);
            chk(16'(status_r), 16'h005A);
         end
      for (int i = 0; i < 14; i++)
         for (int j = 0; j < 32; j++) begin
            sel = j[4:2];
            idx = i > 11 ? sel : br_idx[i];
            f = j[1:0] == 2'h0 ? 8'h01 << idx :
                j[1:0] == 2'h1 ? ~(8'h01 << idx) : {8{j[0]}};
            cond = (i == 8 || i == 9) ? f[2] ^ f[3] : f[idx];
            k = j[2] ? 12'hFF0 : 12'h021;
            e_c = cond == br_pol[i] ? 3'h2 : 3'h1;
            set_flags(f);
            e_pc = e_c == 3'h2 ? rel(k) : pc_m + 16'h0001;
            run_op(br_op[i], k, 8'h00, 8'h00, sel, 1'b0, e_pc, e_c);
            chk(16'(status_r), 16'(f));
            chk(pc_r, e_pc);
         end
      report_and_stop;
   end

   // tests need under 4000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      report_and_stop;
   end
endmodule
